// [bench/sac_adc_model.sv]
`timescale 1ns/1ps
module sac_adc_model import sac_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic csn,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic frameValid,
  output logic [5:0] frameLen,
  output logic [31:0] frameBits,
  output logic ruleErr
);
  logic csnPrev, sclkPrev, dinPrev, readOn, rise;
  logic [3:0] lvlCnt, gapCnt;
  logic [5:0] bitCnt;
  logic [31:0] bits;
  logic [8:0] convCnt;
  logic [15:0] result;
  logic [7:0] cmdByte;
  logic [3:0] pinDir, pinOut;
  assign rise = sclk && !sclkPrev && !csn;
  assign cmdByte = {bits[6:0], din};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {csnPrev, sclkPrev, dinPrev, readOn, dout, frameValid, ruleErr} <= 7'h40;
      {lvlCnt, gapCnt, bitCnt, frameLen} <= 20'hFF000;
      {bits, frameBits, convCnt, result} <= 89'h0;
      {pinDir, pinOut} <= 8'h00;
    end else begin
      csnPrev <= csn;
      sclkPrev <= sclk;
      dinPrev <= din;
      frameValid <= 1'b0;
      lvlCnt <= (sclk != sclkPrev) ? 4'h1 : lvlCnt + {3'h0, lvlCnt != 4'hF};
      gapCnt <= csn ? gapCnt + {3'h0, gapCnt != 4'hF} : 4'h0;
      // high phase exact, low phase may stretch between segments
      if (sclk != sclkPrev && (sclkPrev ? lvlCnt != 4'(HALF_CYCLES) : lvlCnt < 4'(HALF_CYCLES)))
        ruleErr <= 1'b1;
      if (!csn && sclk && sclkPrev && din != dinPrev)
        ruleErr <= 1'b1;
      if ((csn && sclk) || (csnPrev && !csn && gapCnt < 4'(GAP_CYCLES)))
        ruleErr <= 1'b1;
      if (rise) begin
        bits <= {bits[30:0], din};
        bitCnt <= bitCnt + 6'h01;
      end
      if (rise && bitCnt == 6'h07 && cmdByte[7]) begin
        readOn <= 1'b1;
        result <= {cmdByte[2:0], convCnt, 3'h0, convCnt[0]};
        convCnt <= convCnt + 9'h001;
      end
      if (rise && readOn) begin
        dout <= result[15];
        result <= {result[14:0], 1'b0};
      end else if (!readOn) begin
        // released line: toggling so a stale level cannot pass for data
        dout <= ~dout;
      end
      if (!csnPrev && csn) begin
        frameValid <= 1'b1;
        frameLen <= bitCnt;
        frameBits <= bits;
        // only two-byte writes reach the pin registers; reads are never issued here
        if (bitCnt == 6'h10 && bits[12:8] == 5'h06)
          pinDir <= bits[3:0];
        if (bitCnt == 6'h10 && bits[12:8] == 5'h05)
          pinOut <= bits[3:0] & pinDir;
        bitCnt <= 6'h00;
        bits <= 32'h0;
        readOn <= 1'b0;
      end
    end
  end
endmodule // sac_adc_model

// [bench/tb_sac_capture.sv]
`timescale 1ns/1ps
module tb_sac_capture import sac_pkg::*; ;
  logic ref_clk, rst, start, busy, done, sclk, din, dout, csn, edgeSelect, memValid, memReady;
  logic frameValid, ruleErr, stall;
  logic [NUM_REGS-1:0] regWriteEnable;
  logic [NUM_REGS-1:0][BYTE_W-1:0] regInstr, regData;
  logic [NUM_CHAN-1:0] chanEnable;
  logic [NUM_CHAN-1:0][BYTE_W-1:0] chanCommand;
  logic [NUM_CHAN-1:0][MEM_ADDR_W-1:0] chanLow, chanHigh;
  logic [WORD_W-1:0] memData;
  logic [MEM_ADDR_W-1:0] memAddr;
  logic [5:0] frameLen;
  logic [31:0] frameBits, readyPat;
  logic [37:0] expFrame[$];
  logic [38:0] expMem[$];
  int failCount, nChecks, nConv, frameSeen, cyc;

  sac_capture sac_capture_i (.ref_clk(ref_clk), .rst(rst), .start(start), .regWriteEnable(regWriteEnable),
    .regInstr(regInstr), .regData(regData), .chanEnable(chanEnable), .chanCommand(chanCommand),
    .chanLow(chanLow), .chanHigh(chanHigh), .busy(busy), .done(done), .sclk(sclk), .din(din), .dout(dout),
    .csn(csn), .edgeSelect(edgeSelect), .memValid(memValid), .memReady(memReady), .memData(memData),
    .memAddr(memAddr));
  sac_adc_model sac_adc_model_i (.ref_clk(ref_clk), .rst(rst), .csn(csn), .sclk(sclk), .din(din),
    .dout(dout), .frameValid(frameValid), .frameLen(frameLen), .frameBits(frameBits), .ruleErr(ruleErr));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // sink stalls follow a random pattern, or hold off entirely
  always @(negedge ref_clk) begin
    cyc++;
    memReady = !stall && readyPat[cyc % 32];
  end

  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t ns: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask

  task automatic cmpFlag(input logic got, input logic exp);
    compare({63'h0, got}, {63'h0, exp});
  endtask

  always @(posedge ref_clk) begin
    if (frameValid === 1'b1) begin
      frameSeen++;
      compare({26'h0, frameLen, frameBits}, expFrame.size() ? {26'h0, expFrame.pop_front()} : 64'h0);
    end
    if (memValid === 1'b1 && memReady === 1'b1)
      compare({25'h0, memAddr, memData}, expMem.size() ? {25'h0, expMem.pop_front()} : 64'h0);
  end

  function automatic void buildExp();
    for (int r = 0; r < NUM_REGS; r++)
      if (regWriteEnable[r]) expFrame.push_back({6'h10, 16'h0, regInstr[r], regData[r]});
    for (int c = 0; c < NUM_CHAN; c++)
      if (chanEnable[c])
        for (longint a = chanLow[c]; a <= chanHigh[c]; a++) begin
          expFrame.push_back({6'h18, 8'h0, chanCommand[c], 16'h0});
          expMem.push_back({23'(a), chanCommand[c][2:0], 9'(nConv), 3'h0, nConv[0]});
          nConv++;
        end
  endfunction

  task automatic doReset();
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    cmpFlag(csn, 1'b1);
    cmpFlag(sclk | busy | done | memValid | din, 1'b0);
    cmpFlag(edgeSelect, 1'b1);
    expFrame.delete();
    expMem.delete();
    nConv = 0;
    rst = 1'b0;
  endtask

  task automatic randomCfg();
    regWriteEnable = 10'($urandom() | 32'h201);
    chanEnable = 8'($urandom()) | 8'h81;
    for (int i = 0; i < NUM_REGS; i++) begin
      regInstr[i] = {1'b0, 7'($urandom())};
      regData[i] = 8'($urandom());
    end
    for (int c = 0; c < NUM_CHAN; c++) begin
      chanCommand[c] = {1'b1, 4'($urandom()), 3'(c)};
      chanLow[c] = 23'(c * 16 + $urandom_range(3));
      chanHigh[c] = chanLow[c] + 23'($urandom_range(2));
    end
    readyPat = $urandom() | 32'h1;
  endtask

  task automatic launch();
    buildExp();
    frameSeen = 0;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
  endtask

  task automatic finishRun(input string name);
    int k;
    k = 0;
    // a second start while busy must not disturb the sequence
    while ((done !== 1'b1 || expMem.size() != 0) && k < 20000) begin
      @(negedge ref_clk);
      k++;
      start = (k == 400 && busy === 1'b1);
    end
    cmpFlag(done, 1'b1);
    compare(64'(expFrame.size() + expMem.size()), 64'h0);
    cmpFlag(ruleErr, 1'b0);
    cmpFlag(edgeSelect, 1'b1);
    $display("test %s ended at %0t ns", name, $time);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {rst, start, stall, memReady, readyPat} = {4'h8, 32'h1};
    {regWriteEnable, regInstr, regData, chanEnable, chanCommand, chanLow, chanHigh} = '0;
    void'($urandom(77));
    doReset();
    launch();
    repeat (2) @(negedge ref_clk);
    cmpFlag(done, 1'b1);
    finishRun("empty");
    for (int t = 0; t < 2; t++) begin
      randomCfg();
      launch();
      finishRun("random");
    end
    // full buffer at the top of the address space: five commands, then a hold
    regWriteEnable = '0;
    chanEnable = 8'h04;
    chanLow[2] = 23'h7FFFF8;
    chanHigh[2] = 23'h7FFFFF;
    stall = 1'b1;
    launch();
    repeat (3000) @(negedge ref_clk);
    compare(64'(frameSeen), 64'h5);
    cmpFlag(memValid, 1'b1);
    stall = 1'b0;
    finishRun("stall");
    randomCfg();
    launch();
    repeat (700) @(negedge ref_clk);
    doReset();
    launch();
    finishRun("reset mid-run");
    summarize();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    failCount++;
    summarize();
  end
endmodule // tb_sac_capture

// [design/sac_capture.sv]
// Overview of operation
// - edge-select pin held high permanently
// - data changes while clock low, stable high
// - register mode opens with instruction byte
// - data byte follows the instruction byte
// - select raised after every serial command
// - direct command byte picks channel and gain
// - registers initialised first, command before read
// - result presented as one 16-bit word
// - same command repeats per channel
// - address then data per register, then channels
// - parallel load plus start strobe per command byte, one strobe per 16-bit read
// - flag zero sends exactly eight bits
// - flag one captures sixteen result bits
// - sequencer holds until shift completes
// - channel ends at its upper memory address
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic doPush;
  logic doPop;
  assign inReady = count != (PW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sac_fifo

module sac_capture import sac_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [NUM_REGS-1:0] regWriteEnable,
  input wire logic [NUM_REGS-1:0][BYTE_W-1:0] regInstr,
  input wire logic [NUM_REGS-1:0][BYTE_W-1:0] regData,
  input wire logic [NUM_CHAN-1:0] chanEnable,
  input wire logic [NUM_CHAN-1:0][BYTE_W-1:0] chanCommand,
  input wire logic [NUM_CHAN-1:0][MEM_ADDR_W-1:0] chanLow,
  input wire logic [NUM_CHAN-1:0][MEM_ADDR_W-1:0] chanHigh,
  output logic busy,
  output logic done,
  output logic sclk,
  output logic din,
  input wire logic dout,
  output logic csn,
  output logic edgeSelect,
  output logic memValid,
  input wire logic memReady,
  output logic [WORD_W-1:0] memData,
  output logic [MEM_ADDR_W-1:0] memAddr
);
  sac_state_type state;
  logic [NUM_REGS-1:0] regPending;
  logic [NUM_CHAN-1:0] chanPending;
  logic [REG_IDX_W-1:0] regIdx;
  logic [REG_IDX_W-1:0] regCur;
  logic [CHAN_IDX_W-1:0] chanIdx;
  logic [NUM_CHAN-1:0] next_chanPending;
  logic chanFresh;
  logic [CNT_W-1:0] gapCount;
  logic [MEM_ADDR_W-1:0] memAddress;
  logic goShift;
  logic modeFlag;
  logic [BYTE_W-1:0] shiftLoad;
  logic shiftBusy;
  logic shiftDone;
  logic [CNT_W-1:0] halfCount;
  logic [BITS_W-1:0] bitsLeft;
  logic firstBit;
  logic tail;
  logic [BYTE_W-1:0] txShift;
  logic [WORD_W-1:0] rxShift;
  logic [2:0] doutSync;
  logic doutValue;
  logic pushValid;
  logic pushReady;
  logic halfEnd;

  // lowest set bit wins; the sequence order is by index
  always_comb begin
    regIdx = '0;
    for (int i = NUM_REGS - 1; i >= 0; i--) begin
      if (regPending[i]) begin
        regIdx = REG_IDX_W'(i);
      end
    end
    chanIdx = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (chanPending[i]) begin
        chanIdx = CHAN_IDX_W'(i);
      end
    end
    next_chanPending = chanPending;
    next_chanPending[chanIdx] = 1'b0;
  end

  assign edgeSelect = 1'b1;
  assign busy = state != ST_IDLE && state != ST_DONE;
  assign done = state == ST_DONE;
  assign pushValid = state == ST_STORE;
  assign halfEnd = halfCount == HALF_LAST;

  // dout is launched on the converter's clock edge, so it is a foreign input
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      doutSync <= '0;
      doutValue <= 1'b0;
    end else begin
      doutSync <= {doutSync[1:0], dout};
      if (doutSync[1] == doutSync[2]) begin
        doutValue <= doutSync[2];
      end
    end
  end

  // sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      csn <= 1'b1;
      goShift <= 1'b0;
      modeFlag <= 1'b0;
      shiftLoad <= '0;
      gapCount <= '0;
      regCur <= '0;
      memAddress <= '0;
      chanFresh <= 1'b0;
      regPending <= '0;
      chanPending <= '0;
    end else begin
      goShift <= 1'b0;
      unique case (state)
        ST_IDLE, ST_DONE: begin
          gapCount <= '0;
          if (start) begin
            regPending <= regWriteEnable;
            chanPending <= chanEnable;
            chanFresh <= 1'b1;
            if (|regWriteEnable) begin
              state <= ST_WRITE_ADDR;
            end else if (|chanEnable) begin
              state <= ST_DIRECT_MODE;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_WRITE_ADDR: begin
          if (gapCount == GAP_LAST) begin
            csn <= 1'b0;
            goShift <= 1'b1;
            shiftLoad <= regInstr[regIdx];
            regCur <= regIdx;
            regPending[regIdx] <= 1'b0;
            state <= ST_WAIT_ADDR;
          end else begin
            gapCount <= gapCount + 1'b1;
          end
        end
        ST_WAIT_ADDR: begin
          if (shiftDone) begin
            state <= ST_ADDR_DATA;
          end
        end
        ST_ADDR_DATA: begin
          goShift <= 1'b1;
          shiftLoad <= regData[regCur];
          state <= ST_WAIT_DATA;
        end
        ST_WAIT_DATA: begin
          if (shiftDone) begin
            csn <= 1'b1;
            gapCount <= '0;
            if (|regPending) begin
              state <= ST_WRITE_ADDR;
            end else if (|chanPending) begin
              state <= ST_DIRECT_MODE;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_DIRECT_MODE: begin
          if (gapCount == GAP_LAST) begin
            csn <= 1'b0;
            goShift <= 1'b1;
            modeFlag <= 1'b0;
            shiftLoad <= chanCommand[chanIdx];
            if (chanFresh) begin
              memAddress <= chanLow[chanIdx];
              chanFresh <= 1'b0;
            end
            state <= ST_WAIT_DM;
          end else begin
            gapCount <= gapCount + 1'b1;
          end
        end
        ST_WAIT_DM: begin
          if (shiftDone) begin
            state <= ST_ASSIGN_DATA;
          end
        end
        ST_ASSIGN_DATA: begin
          // result follows the command with no read instruction
          modeFlag <= 1'b1;
          goShift <= 1'b1;
          state <= ST_READ_DATA;
        end
        ST_READ_DATA: begin
          if (shiftDone) begin
            csn <= 1'b1;
            modeFlag <= 1'b0;
            gapCount <= '0;
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          // a full buffer stalls the next conversion, no sample is dropped
          if (pushReady) begin
            if (memAddress == chanHigh[chanIdx]) begin
              chanPending <= next_chanPending;
              chanFresh <= 1'b1;
              state <= (|next_chanPending) ? ST_DIRECT_MODE : ST_DONE;
            end else begin
              memAddress <= memAddress + 1'b1;
              state <= ST_DIRECT_MODE;
            end
          end
        end
      endcase
    end
  end

  // shift engine; sclk is a divided copy of ref_clk, so no second domain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk <= 1'b0;
      din <= 1'b0;
      shiftBusy <= 1'b0;
      shiftDone <= 1'b0;
      halfCount <= '0;
      bitsLeft <= '0;
      firstBit <= 1'b0;
      tail <= 1'b0;
      txShift <= '0;
      rxShift <= '0;
    end else begin
      shiftDone <= 1'b0;
      if (goShift && !shiftBusy) begin
        shiftBusy <= 1'b1;
        txShift <= shiftLoad;
        bitsLeft <= modeFlag ? BITS_RESULT : BITS_CMD;
        halfCount <= '0;
        firstBit <= 1'b1;
        tail <= 1'b0;
        sclk <= 1'b0;
        din <= modeFlag ? 1'b0 : shiftLoad[MSB_POS];
      end else if (shiftBusy) begin
        if (!halfEnd) begin
          halfCount <= halfCount + 1'b1;
        end else begin
          halfCount <= '0;
          if (!sclk) begin
            // capture at the end of the low phase: dout moved on the
            // previous rising edge and has cleared the synchroniser by now
            if (!firstBit) begin
              rxShift <= {rxShift[WORD_W-2:0], doutValue};
            end
            firstBit <= 1'b0;
            if (tail) begin
              shiftBusy <= 1'b0;
              shiftDone <= 1'b1;
              tail <= 1'b0;
            end else begin
              sclk <= 1'b1;
            end
          end else begin
            sclk <= 1'b0;
            txShift <= {txShift[BYTE_W-2:0], 1'b0};
            if (bitsLeft == 5'h01) begin
              tail <= 1'b1;
              din <= 1'b0;
            end else begin
              bitsLeft <= bitsLeft - 1'b1;
              din <= modeFlag ? 1'b0 : txShift[MSB_POS-1];
            end
          end
        end
      end
    end
  end

  sac_fifo #(
    .WIDTH(WORD_W + MEM_ADDR_W),
    .DEPTH(FIFO_DEPTH)
  ) sac_fifo_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData({memAddress, rxShift}),
    .outValid(memValid),
    .outReady(memReady),
    .outData({memAddr, memData})
  );

  // checking helpers
  logic [BITS_W:0] riseCount;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      riseCount <= '0;
    end else if (goShift && !shiftBusy) begin
      riseCount <= '0;
    end else if (shiftBusy && !sclk && halfEnd && !tail) begin
      riseCount <= riseCount + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_edge_sel_high: assert property (edgeSelect == 1'b1)
    else $error("edge select not high");
  a_din_stable_high: assert property (sclk && $past(sclk) |-> $stable(din))
    else $error("din moved while sclk high");
  a_sclk_full_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk [*4])
    else $error("sclk phase length wrong");
  a_cs_after_read: assert property (state == ST_READ_DATA && shiftDone |=> csn)
    else $error("select not raised after command");
  a_init_first: assert property (state == ST_DIRECT_MODE |-> regPending == '0)
    else $error("conversion before init done");
  a_cmd_eight_bits: assert property (shiftDone && !modeFlag |-> riseCount == 6'h08)
    else $error("command shift not 8 bits");
  a_read_sixteen_bits: assert property (shiftDone && modeFlag |-> riseCount == 6'h10)
    else $error("result shift not 16 bits");
  a_hold_until_done: assert property (state == ST_WAIT_ADDR && !shiftDone |=> state == ST_WAIT_ADDR)
    else $error("sequencer left hold early");
  a_start_strobe: assert property (goShift && !shiftBusy |=> shiftBusy ##[1:200] shiftDone)
    else $error("shift did not complete");
  a_same_command: assert property (state == ST_WAIT_DM && $past(state) == ST_DIRECT_MODE |-> shiftLoad == $past(chanCommand[chanIdx]))
    else $error("wrong direct command");
  a_data_byte: assert property (state == ST_WAIT_DATA && $past(state) == ST_ADDR_DATA |-> shiftLoad == $past(regData[regCur]))
    else $error("wrong register data byte");
  a_channel_end: assert property (pushValid && pushReady && memAddress == chanHigh[chanIdx] |=> !chanPending[$past(chanIdx)])
    else $error("channel not retired at upper address");
  a_idle_lines: assert property (state == ST_IDLE |-> csn && !sclk)
    else $error("idle lines wrong");

  c_reg_write: cover property (state == ST_WAIT_DATA && shiftDone);
  c_sample_stored: cover property (pushValid && pushReady);
  c_fifo_stall: cover property (pushValid && !pushReady);
  c_all_done: cover property ($rose(done));
endmodule // sac_capture

// [design/sac_pkg.sv]
package sac_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS = 200;
  localparam int CS_GAP_NS = 400;
  // least times round up to whole cycles
  localparam int HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYCLES = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
  localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYCLES - 1);
  localparam int NUM_REGS = 10;
  localparam int REG_IDX_W = 4;
  localparam int NUM_CHAN = 8;
  localparam int CHAN_IDX_W = 3;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int MEM_ADDR_W = 23;
  localparam int FIFO_DEPTH = 4;
  localparam int BITS_W = 5;
  localparam logic [BITS_W-1:0] BITS_CMD = 5'h08;
  localparam logic [BITS_W-1:0] BITS_RESULT = 5'h10;
  localparam int MSB_POS = 7;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WRITE_ADDR = 4'h1,
    ST_WAIT_ADDR = 4'h2,
    ST_ADDR_DATA = 4'h3,
    ST_WAIT_DATA = 4'h4,
    ST_DIRECT_MODE = 4'h5,
    ST_WAIT_DM = 4'h6,
    ST_ASSIGN_DATA = 4'h7,
    ST_READ_DATA = 4'h8,
    ST_STORE = 4'h9,
    ST_DONE = 4'hA
  } sac_state_type;
endpackage
